/* pkg/stl_defines.vh */
// Constants for the share trim and start-up logger block.
// Assumes one 100 MHz clock; included by bare name.
`ifndef STL_DEFINES_VH
`define STL_DEFINES_VH
`define STL_CMD_SHARE      8'hda
`define STL_CMD_RAMP       8'hdb
`define STL_CMD_TSEL       8'hdc
`define STL_CMD_VINOFS     8'hdd
`define STL_CMD_TRIMMON    8'hde
`define STL_CMD_STATUS     8'hdf
`define STL_SH_LIMIT_LSB   24
`define STL_SH_POS_LSB     8
`define STL_SH_NEG_LSB     0
`define STL_SH_EN_BIT      56
`define STL_SH_RESET       64'h0000_0000_0000_0000
`define STL_TSEL_RESET     8'h00
`define STL_RAMP_SAMPLES   15
`define STL_STAT_WORDS     16
`define STL_STAT_PERIOD_S  8
`define STL_CLK_HZ         100000000
`define STL_STAT_CYCLES    (`STL_STAT_PERIOD_S * `STL_CLK_HZ)
`define STL_TRIM_STEP_CYC  1000
`endif

/* rtl/stl_sync3.v */
// Three-stage synchroniser with agreement filter for one level.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ns
module stl_sync3 (
    input  wire clk_in,
    input  wire rst_in,
    input  wire d_in,
    output reg  q_out
);
    reg s1;
    reg s2;
    reg s3;
    // First stage feeds only the second; change accepted when 2 and 3 agree
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            q_out <= 1'b0;
        end else begin
            s1 <= d_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                q_out <= s3;
        end
    end
endmodule // stl_sync3

/* rtl/stl_share_logger.v */
// Share trim controller plus start-up ramp and status recorders,
// with a command-coded register port for the management link transport.
// Assumes the transport presents one command at a time and sample inputs are on CLK_IN.
// Assumes the transport decodes block lengths itself; this port always shows all 256 bits.
// The CTRL pin is the only input from outside the clock domain and is synchronised here.
// Functional notes
// - Trim steps never carry the magnitude past the limit byte, 1.7 mV per count.
// - Current above positive threshold steps trim upward.
// - Current below negative threshold steps trim downward.
// - Between thresholds the trim holds unchanged.
// - Enable bit 56 gates all share trimming.
// - Record 15 Vin/Vout pairs during ramp at ramp-time-scaled interval.
// - Store snapshot count plus one just before ramp starts.
// - Only the first ramp per power cycle is recorded.
// - Ramp record cleared after a successful ramp up.
// - Ramp read: counter low 16 bits, then Vin n, Vout n byte pairs.
// - Sensor select bit 0 picks internal (0) or external (1) sensor.
// - Vin offset read: on offset high half, off offset low half.
// - After ramp, one status word every 8 s, 16 words.
// - Status read: word n in bits 16n+15 down to 16n.
`timescale 1ns/1ns
`include "stl_defines.vh"
module stl_share_logger #(
    parameter [31:0] STAT_CYCLES  = `STL_STAT_CYCLES,
    parameter [31:0] TRIM_STEP    = `STL_TRIM_STEP_CYC,
    parameter        NSAMP        = `STL_RAMP_SAMPLES,
    parameter        NSTAT        = `STL_STAT_WORDS
) (
    input  wire         CLK_IN,
    input  wire         RST_IN,
    input  wire [7:0]   CMD_CODE_IN,
    input  wire         CMD_WR_IN,
    input  wire [63:0]  CMD_WDATA_IN,
    output reg  [255:0] CMD_RDATA_OUT,
    output wire         CMD_HIT_OUT,
    input  wire [7:0]   IOUT_IN,
    input  wire [7:0]   VIN_SAMPLE_IN,
    input  wire [7:0]   VOUT_SAMPLE_IN,
    input  wire [15:0]  STATUS_WORD_IN,
    input  wire [15:0]  SNAP_CYCLES_IN,
    input  wire [15:0]  VIN_OFS_ON_IN,
    input  wire [15:0]  VIN_OFS_OFF_IN,
    input  wire [31:0]  RAMP_TIME_CYC_IN,
    input  wire         RAMP_START_IN,
    input  wire         RAMP_DONE_IN,
    input  wire         CTRL_PIN_IN,
    output reg  [15:0]  VOUT_TRIM_OUT,
    output reg          TEMP_EXT_SEL_OUT,
    output reg          SHARE_ACTIVE_OUT
);
    // Recorder phases, one-hot; the sequence only ever moves forward
    // until the next reset, which is how one power cycle is modelled.
    localparam ST_IDLE = 4'b0001;
    localparam ST_RAMP = 4'b0010;
    localparam ST_STAT = 4'b0100;
    localparam ST_DONE = 4'b1000;

    // Threshold block copy and the two record images
    reg  [63:0]  share_thr;
    reg  [255:0] ramp_rec;
    wire [255:0] stat_rec;
    reg  [15:0]  stat_slot [0:NSTAT-1];
    // Sequencer and its pacing counters
    reg  [3:0]   state;
    reg  [3:0]   next_state;
    reg  [31:0]  tick;
    reg  [31:0]  ramp_iv;
    reg  [3:0]   idx;
    // Share trim state and its next values
    reg  [31:0]  step_cnt;
    reg  signed [15:0] trim;
    reg  signed [15:0] next_trim;
    reg          next_active;
    reg          ramp_seen;
    wire         ctrl_sync;
    wire [7:0]   lim   = share_thr[`STL_SH_LIMIT_LSB+7:`STL_SH_LIMIT_LSB];
    wire [7:0]   pos_t = share_thr[`STL_SH_POS_LSB+7:`STL_SH_POS_LSB];
    wire [7:0]   neg_t = share_thr[`STL_SH_NEG_LSB+7:`STL_SH_NEG_LSB];
    wire         sh_en = share_thr[`STL_SH_EN_BIT];
    wire signed [15:0] lim_s = {8'h00, lim};
    // Step pacing and threshold compares for the trim path; both thresholds
    // are strict, so a current exactly on a threshold counts as inside the band
    wire         step_due = (step_cnt >= TRIM_STEP - 32'h1);
    wire         cur_high = (IOUT_IN > pos_t);
    wire         cur_low  = (IOUT_IN < neg_t);
    // A status slot is due when the capture period expires in the status phase
    wire         stat_take = (state == ST_STAT) && (tick >= STAT_CYCLES - 32'h1);

    // Command decode used for both hit flag and write steering;
    // the group's codes are contiguous, so a range compare is enough
    function known_cmd;
        input [7:0] c;
        begin
            known_cmd = (c >= `STL_CMD_SHARE) && (c <= `STL_CMD_STATUS);
        end
    endfunction

    assign CMD_HIT_OUT = known_cmd(CMD_CODE_IN);

    // CTRL pin enters from outside the clock domain; a glitch shorter
    // than one clock never reaches the trim output
    stl_sync3 u_ctrl_sync (
        .clk_in (CLK_IN),
        .rst_in (RST_IN),
        .d_in   (CTRL_PIN_IN),
        .q_out  (ctrl_sync)
    );

    // Writable registers; read-only commands ignore writes.
    // Codes outside the group are filtered first, so a stray write is dropped.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            share_thr        <= `STL_SH_RESET;
            TEMP_EXT_SEL_OUT <= 1'b0;
        end else if (CMD_WR_IN && known_cmd(CMD_CODE_IN)) begin
            if (CMD_CODE_IN == `STL_CMD_SHARE)
                share_thr <= CMD_WDATA_IN;
            if (CMD_CODE_IN == `STL_CMD_TSEL)
                TEMP_EXT_SEL_OUT <= CMD_WDATA_IN[0];
        end
    end

    // Next trim value: one count toward the side the current points to.
    // The clamp sits in the same path, so a limit lowered while the trim
    // stands above it pulls the trim back only at a step with current above the positive threshold.
    always @* begin
        next_trim   = trim;
        next_active = SHARE_ACTIVE_OUT;
        if (cur_high) begin
            next_active = 1'b1;
            if (trim < lim_s)
                next_trim = trim + 16'sh0001;
            else
                next_trim = lim_s;
        end else if (cur_low) begin
            next_active = 1'b1;
            if (trim > -lim_s)
                next_trim = trim - 16'sh0001;
            else
                next_trim = -lim_s;
        end else begin
            next_active = 1'b0;
        end
    end

    // Share trim register: step rate limited so the outer voltage loop can settle.
    // Turning sharing off drops the trim at once rather than walking it back.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            trim             <= 16'sh0000;
            step_cnt         <= 32'h0000_0000;
            SHARE_ACTIVE_OUT <= 1'b0;
        end else if (!sh_en) begin
            trim             <= 16'sh0000;
            step_cnt         <= 32'h0000_0000;
            SHARE_ACTIVE_OUT <= 1'b0;
        end else if (!step_due) begin
            step_cnt <= step_cnt + 32'h1;
        end else begin
            step_cnt         <= 32'h0000_0000;
            trim             <= next_trim;
            SHARE_ACTIVE_OUT <= next_active;
        end
    end

    // Applied trim; the CTRL pin low forces no trim since output is off.
    // The trim register itself keeps running, so turning back on
    // resumes at the balanced value instead of starting from zero.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN)
            VOUT_TRIM_OUT <= 16'h0000;
        else
            VOUT_TRIM_OUT <= ctrl_sync ? trim : 16'h0000;
    end

    // Recorder sequencing: idle until the first ramp, then ramp capture,
    // then the status window, then parked until reset
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (RAMP_START_IN && !ramp_seen)
                    next_state = ST_RAMP;
            end
            ST_RAMP: begin
                if (RAMP_DONE_IN)
                    next_state = ST_STAT;
            end
            ST_STAT: begin
                // Leave on the same edge that writes the last slot
                if (stat_take && idx == NSTAT - 1)
                    next_state = ST_DONE;
            end
            ST_DONE: next_state = ST_DONE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Recorders; ramp interval is the ramp time spread over the sample count.
    // The interval is rounded up by one, so the last sample lands between one
    // and the sample count in cycles after the ramp time has passed.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state     <= ST_IDLE;
            ramp_rec  <= 256'h0;
            tick      <= 32'h0000_0000;
            ramp_iv   <= 32'h0000_0001;
            idx       <= 4'h0;
            ramp_seen <= 1'b0;
        end else begin
            state <= next_state;
            case (state)
                ST_IDLE: begin
                    // Counter and interval are latched before the first sample
                    if (RAMP_START_IN && !ramp_seen) begin
                        ramp_seen      <= 1'b1;
                        ramp_rec       <= 256'h0;
                        ramp_rec[15:0] <= SNAP_CYCLES_IN + 16'h0001;
                        ramp_iv        <= (RAMP_TIME_CYC_IN / NSAMP) + 32'h1;
                        tick           <= 32'h0000_0000;
                        idx            <= 4'h0;
                    end
                end
                ST_RAMP: begin
                    if (RAMP_DONE_IN) begin
                        ramp_rec <= 256'h0;
                        tick     <= 32'h0000_0000;
                        idx      <= 4'h0;
                    end else if (tick >= ramp_iv - 32'h1) begin
                        tick <= 32'h0000_0000;
                        if (idx < NSAMP) begin
                            ramp_rec[16*idx+16 +: 8] <= VIN_SAMPLE_IN;
                            ramp_rec[16*idx+24 +: 8] <= VOUT_SAMPLE_IN;
                            idx <= idx + 4'h1;
                        end
                    end else begin
                        tick <= tick + 32'h1;
                    end
                end
                ST_STAT: begin
                    // The slot write itself sits in the status slot registers
                    if (stat_take) begin
                        tick <= 32'h0000_0000;
                        idx  <= idx + 4'h1;
                    end else begin
                        tick <= tick + 32'h1;
                    end
                end
                default: begin
                    tick <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Status slots: one register per word, written only at its own instant.
    // Slots not yet reached keep their reset zero, so a read during the
    // capture window shows how far the recording has come.
    genvar gw;
    generate
        for (gw = 0; gw < NSTAT; gw = gw + 1) begin : g_stat
            always @(posedge CLK_IN or posedge RST_IN) begin
                if (RST_IN)
                    stat_slot[gw] <= 16'h0000;
                else if (stat_take && idx == gw)
                    stat_slot[gw] <= STATUS_WORD_IN;
            end
            assign stat_rec[16*gw +: 16] = stat_slot[gw];
        end
    endgenerate

    // Registered read answer for the addressed command.
    // The answer follows the code with one cycle of latency; a block read
    // is a snapshot of one cycle, so a capture cannot tear a word in half.
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN)
            CMD_RDATA_OUT <= 256'h0;
        else begin
            case (CMD_CODE_IN)
                `STL_CMD_SHARE:   CMD_RDATA_OUT <= {192'h0, share_thr};
                `STL_CMD_RAMP:    CMD_RDATA_OUT <= ramp_rec;
                `STL_CMD_TSEL:    CMD_RDATA_OUT <= {255'h0, TEMP_EXT_SEL_OUT};
                `STL_CMD_VINOFS:  CMD_RDATA_OUT <= {224'h0, VIN_OFS_ON_IN, VIN_OFS_OFF_IN};
                `STL_CMD_TRIMMON: CMD_RDATA_OUT <= {240'h0, VOUT_TRIM_OUT};
                `STL_CMD_STATUS:  CMD_RDATA_OUT <= stat_rec;
                default:          CMD_RDATA_OUT <= 256'h0;
            endcase
        end
    end
endmodule // stl_share_logger

/* tb/stl_checker.sv */
// Port assertions for the share logger.
// Bound into every stl_share_logger instance; one clock domain.
`timescale 1ns/1ns
module stl_checker (
    input wire         CLK_IN,
    input wire         RST_IN,
    input wire [7:0]   CMD_CODE_IN,
    input wire         CMD_WR_IN,
    input wire [63:0]  CMD_WDATA_IN,
    input wire [255:0] CMD_RDATA_OUT,
    input wire [7:0]   IOUT_IN,
    input wire [15:0]  VIN_OFS_ON_IN,
    input wire [15:0]  VIN_OFS_OFF_IN,
    input wire [15:0]  VOUT_TRIM_OUT,
    input wire         TEMP_EXT_SEL_OUT
);
    reg  [63:0]        sh;
    wire signed [16:0] lim  = {9'h0, sh[31:24]};
    wire signed [16:0] trim = {VOUT_TRIM_OUT[15], VOUT_TRIM_OUT};
    wire               en   = sh[56];
    wire               band = (IOUT_IN >= sh[7:0]) && (IOUT_IN <= sh[15:8]);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Shadow of the threshold block, since limit and enable are not on the ports
    always @(posedge CLK_IN or posedge RST_IN)
        if (RST_IN) sh <= 64'h0;
        else if (CMD_WR_IN && CMD_CODE_IN == 8'hda) sh <= CMD_WDATA_IN;
    a_trim_limit: assert property (trim <= lim && trim >= -lim)
        else $error("trim beyond limit");
    a_trim_up: assert property (trim > $past(trim) |-> !$past(en, 2) || $past(IOUT_IN, 2) > $past(sh[15:8], 2))
        else $error("trim rose without high current");
    a_trim_down: assert property (trim < $past(trim) |-> !$past(en, 2) || $past(IOUT_IN, 2) < $past(sh[7:0], 2))
        else $error("trim fell without low current");
    a_band_hold: assert property ($past(en, 2) && $past(band, 2) |-> $stable(VOUT_TRIM_OUT))
        else $error("trim moved inside band");
    a_share_gate: assert property (!en [*3] |-> VOUT_TRIM_OUT == 16'h0)
        else $error("trim while sharing off");
    a_share_read: assert property (CMD_CODE_IN == 8'hda && !CMD_WR_IN |=> CMD_RDATA_OUT[63:0] == $past(sh))
        else $error("threshold readback wrong");
    a_tsel_write: assert property (CMD_WR_IN && CMD_CODE_IN == 8'hdc |=> TEMP_EXT_SEL_OUT == $past(CMD_WDATA_IN[0]))
        else $error("sensor select wrong");
    a_vin_offset: assert property (CMD_CODE_IN == 8'hdd |=> CMD_RDATA_OUT[31:0] == {$past(VIN_OFS_ON_IN), $past(VIN_OFS_OFF_IN)})
        else $error("offset read wrong");
    a_trim_monitor: assert property (CMD_CODE_IN == 8'hde |=> CMD_RDATA_OUT[15:0] == $past(VOUT_TRIM_OUT))
        else $error("trim monitor wrong");
    c_top: cover property (trim == lim && lim != 0);
    c_bottom: cover property (trim == -lim && lim != 0);
    c_ramp: cover property (CMD_CODE_IN == 8'hdb ##1 CMD_RDATA_OUT != 256'h0);
endmodule // stl_checker
bind stl_share_logger stl_checker chk_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CMD_CODE_IN(CMD_CODE_IN),
    .CMD_WR_IN(CMD_WR_IN), .CMD_WDATA_IN(CMD_WDATA_IN), .CMD_RDATA_OUT(CMD_RDATA_OUT), .IOUT_IN(IOUT_IN),
    .VIN_OFS_ON_IN(VIN_OFS_ON_IN), .VIN_OFS_OFF_IN(VIN_OFS_OFF_IN), .VOUT_TRIM_OUT(VOUT_TRIM_OUT),
    .TEMP_EXT_SEL_OUT(TEMP_EXT_SEL_OUT));

/* tb/stl_host.sv */
// Host model on the command port, one command at a time.
// Assumes the bench calls put and get through the instance.
`timescale 1ns/1ns
module stl_host (
    input  wire         clk_in,
    input  wire [255:0] rdata_in,
    output reg  [7:0]   code_out,
    output reg          wr_out,
    output reg  [63:0]  wdata_out
);
    initial begin
        code_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 64'h0;
    end
    // Write: code and data held with the strobe across one taking edge
    task put(input [7:0] c, input [63:0] d);
        begin
            @(posedge clk_in);
            code_out <= c;
            wdata_out <= d;
            wr_out <= 1'b1;
            @(posedge clk_in);
            wr_out <= 1'b0;
            wdata_out <= ~d; // Stale data is not left looking valid
        end
    endtask
    // Read: answer lands one edge after the code; taken mid-cycle once settled
    task get(input [7:0] c, output [255:0] r);
        begin
            @(posedge clk_in);
            code_out <= c;
            @(posedge clk_in);
            @(negedge clk_in);
            r = rdata_in;
            @(posedge clk_in);
        end
    endtask
endmodule // stl_host

/* tb/tb.sv */
// Self-checking bench: register map, share trim, ramp and status recorders.
// Host model drives the command port; the checker is bound in.
`timescale 1ns/1ns
module tb;
    reg          clk, rst, st, dn;
    reg  [7:0]   iout, vi, vo, lim;
    reg  [15:0]  sw, snap, ofon, ofoff, nl;
    wire [7:0]   code;
    wire         wr, hit, tsel, act;
    wire [63:0]  wd;
    wire [255:0] rd;
    wire [15:0]  vtrim;
    reg  [255:0] r, e;
    integer      seed, errors, num_checks, i;
    stl_share_logger #(.STAT_CYCLES(32'd20), .TRIM_STEP(32'd4)) dut_u (.CLK_IN(clk), .RST_IN(rst),
        .CMD_CODE_IN(code), .CMD_WR_IN(wr), .CMD_WDATA_IN(wd), .CMD_RDATA_OUT(rd), .CMD_HIT_OUT(hit),
        .IOUT_IN(iout), .VIN_SAMPLE_IN(vi), .VOUT_SAMPLE_IN(vo), .STATUS_WORD_IN(sw), .SNAP_CYCLES_IN(snap),
        .VIN_OFS_ON_IN(ofon), .VIN_OFS_OFF_IN(ofoff), .RAMP_TIME_CYC_IN(32'd150), .RAMP_START_IN(st),
        .RAMP_DONE_IN(dn), .CTRL_PIN_IN(1'b1), .VOUT_TRIM_OUT(vtrim), .TEMP_EXT_SEL_OUT(tsel),
        .SHARE_ACTIVE_OUT(act));
    stl_host h (.clk_in(clk), .rdata_in(rd), .code_out(code), .wr_out(wr), .wdata_out(wd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // One comparison, counted; a mismatch is reported at once
    task chk(input [255:0] got, input [255:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checks=%0d errors=%0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // Expected ramp block: counter then identical Vin/Vout pairs
    function [255:0] ramp_rec(input [15:0] s, input [7:0] a, input [7:0] b);
        integer n;
        begin
            ramp_rec = {240'h0, s + 16'h1};
            for (n = 0; n < 15; n = n + 1)
                ramp_rec[16*n+16 +: 16] = {b, a};
        end
    endfunction
    initial begin
        seed = 32'heefd; errors = 0; num_checks = 0;
        rst = 1'b1; st = 1'b0; dn = 1'b0; iout = 8'h0; vi = 8'h0; vo = 8'h0;
        sw = 16'h0; snap = 16'h0; ofon = 16'h0; ofoff = 16'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        ofon <= $random(seed); ofoff <= $random(seed);
        h.get(8'hda, r); chk(r[63:0], 64'h0);
        for (i = 0; i < 2; i = i + 1) begin
            h.put(8'hdc, i); h.get(8'hdc, r); chk(tsel, i[0]);
        end
        h.put(8'hdd, 64'hffff); h.get(8'hdd, r); chk(r[31:0], {ofon, ofoff});
        h.get(8'h20, r); chk(r, 256'h0); chk(hit, 1'b0);
        $display("register map test done");
        // Share trim: high, upper band edge, low, lower band edge, then disabled
        lim = 8'd1 + {$random(seed)} % 20; nl = 16'h0 - {8'h0, lim};
        h.put(8'hda, {7'h0, 1'b1, 24'h0, lim, 8'h0, 8'd100, 8'd50});
        iout <= 8'd101 + {$random(seed)} % 150; repeat (300) @(posedge clk); chk(vtrim, lim);
        h.get(8'hde, r); chk(r[15:0], lim);
        iout <= 8'd100; repeat (100) @(posedge clk); chk(vtrim, lim);
        iout <= {$random(seed)} % 50; repeat (600) @(posedge clk); chk(vtrim, nl);
        iout <= 8'd50; repeat (100) @(posedge clk); chk(vtrim, nl);
        h.put(8'hda, {32'h0, lim, 8'h0, 8'd100, 8'd50}); repeat (10) @(posedge clk); chk(vtrim, 16'h0);
        $display("share trim test done");
        // First ramp recorded, second ignored, success clears
        snap <= $random(seed); vi <= $random(seed); vo <= $random(seed);
        @(posedge clk); st <= 1'b1; @(posedge clk); st <= 1'b0;
        repeat (200) @(posedge clk);
        e = ramp_rec(snap, vi, vo);
        h.get(8'hdb, r); chk(r, e);
        vi <= ~vi; snap <= ~snap; st <= 1'b1; @(posedge clk); st <= 1'b0;
        repeat (200) @(posedge clk);
        h.get(8'hdb, r); chk(r, e);
        sw <= $random(seed); dn <= 1'b1; @(posedge clk); dn <= 1'b0;
        h.get(8'hdb, r); chk(r, 256'h0);
        $display("ramp record test done");
        // Sixteen status copies, then capture stops
        repeat (400) @(posedge clk);
        h.get(8'hdf, r); chk(r, {16{sw}});
        sw <= ~sw; repeat (100) @(posedge clk);
        h.get(8'hdf, r); chk(r, {16{~sw}});
        $display("status record test done");
        results;
    end
endmodule // tb
